/* verilog/scf_pkg.sv */
package scf_pkg;
  localparam int CLK_MHZ = 10;
  // converter_control layout
  localparam logic [15:0] CTRL_RESET = 16'h4000;
  localparam int CTRL_INT_REF_EN = 3;
  localparam int CTRL_CS_EN = 9;
  localparam int CTRL_STATUS_APPEND = 10;
  localparam int CTRL_OUT_DIS_DELAY = 12;
  localparam int CTRL_INT_REF_LEVEL = 13;
  // command byte: bit 6 selects read, bits 5:0 select the register
  localparam int CMD_READ_BIT = 6;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CONTROL = 6'h01;
  localparam logic [5:0] ADDR_DATA = 6'h02;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] WORD_BITS = 6'h10;
  localparam logic [5:0] DATA_BITS = 6'h18;
  localparam int BUF_W = 32;
  // pin release delay after the last clock edge in 3-wire mode
  localparam int DIS_SHORT_NS = 10;
  localparam int DIS_LONG_NS = 100;
  localparam int DIS_SHORT_RAW = (DIS_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int DIS_LONG_RAW = (DIS_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DIS_SHORT_CYC = 4'(DIS_SHORT_RAW < 1 ? 1 : DIS_SHORT_RAW);
  localparam logic [3:0] DIS_LONG_CYC = 4'(DIS_LONG_RAW < 1 ? 1 : DIS_LONG_RAW);
  typedef enum logic [1:0] {SCF_CMD, SCF_DATA, SCF_WAIT} scf_state_t;
endpackage

/* verilog/scf_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module scf_buf2
  import scf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [BUF_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [BUF_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [BUF_W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] cnt;
  logic push;
  logic pop;
  logic [1:0] next_cnt;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      cnt <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      cnt <= next_cnt;
      in_ready <= next_cnt != 2'h2;
      out_valid <= next_cnt != 2'h0;
    end
  end
endmodule
`default_nettype wire

/* verilog/scf_top.sv */
// Summary of operation
// - status_append_enable set appends status byte to data reads; clear sends data only.
// - appended read shifts data 23..0 then status 7..0 without gap.
// - chip_select_enable clear: 3-wire, frame ends on final SCLK rising edge.
// - 3-wire: pin switches from data to ready one release delay after the last SCLK rise.
// - 3-wire: CS high tristates the shared data/ready pin.
// - status and CRC bytes lengthen the frame; both ends count them.
// - chip_select_enable set: 4-wire, frame ends on CS rising edge.
// - 4-wire: pin switches from data to ready when CS rises.
// - write, read and clock count errors reported only in 4-wire mode.
// - reference enable bit gates the reference pin, which follows the level bit.
// - output_disable_delay picks short or long pin release delay in 3-wire.
`timescale 1ns/1ps
`default_nettype none
module scf_top
  import scf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic data_out_ready_pin,
  output logic data_out_ready_oe,
  input wire logic [23:0] conv_data,
  input wire logic [7:0] conv_status,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic ready_on_pin,
  input wire logic crc_enable,
  input wire logic error_check_enable,
  output logic [15:0] converter_control,
  output logic reference_output_pin,
  output logic write_error_flag,
  output logic read_error_flag,
  output logic clock_count_error_flag
);
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] din_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic four_wire;
  scf_state_t state;
  logic [5:0] bit_cnt;
  logic [5:0] frame_len;
  logic [7:0] cmd_sh;
  logic [7:0] cmd;
  logic [31:0] rx;
  logic [47:0] tx;
  logic drive_data;
  logic [3:0] dly_cnt;
  logic pop;
  logic ctrl_wr;
  logic wr_due;
  logic [15:0] ctrl_val;
  logic [BUF_W-1:0] buf_data;
  logic buf_valid;
  logic [7:0] full_cmd;
  logic [5:0] next_cnt;

  function automatic logic [5:0] frame_bits(input logic [7:0] c, input logic app,
                                            input logic crc);
    logic [5:0] n;
    n = CMD_BITS;
    unique case (c[5:0])
      ADDR_CONTROL: n = n + WORD_BITS;
      ADDR_DATA: n = n + DATA_BITS;
      default: n = n + BYTE_BITS;
    endcase
    if (app && c[CMD_READ_BIT] && c[5:0] == ADDR_DATA) begin
      n = n + BYTE_BITS;
    end
    if (crc) begin
      n = n + BYTE_BITS;
    end
    return n;
  endfunction

  function automatic logic known_addr(input logic [5:0] a);
    return a == ADDR_STATUS || a == ADDR_CONTROL || a == ADDR_DATA;
  endfunction

  // the third stage only serves edge detection, never the first stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 3'h7;
      cs_s <= 3'h7;
      din_s <= 2'h0;
    end else if (ce) begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[1:0], cs_n};
      din_s <= {din_s[0], din};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign four_wire = converter_control[CTRL_CS_EN];
  assign full_cmd = {cmd_sh[6:0], din_s[1]};
  assign next_cnt = 6'(bit_cnt + 6'h01);
  assign frame_len = frame_bits(cmd, converter_control[CTRL_STATUS_APPEND], crc_enable);

  // frame tracking, command decode and write capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= SCF_CMD;
      bit_cnt <= 6'h00;
      cmd_sh <= 8'h00;
      cmd <= 8'h00;
      rx <= 32'h0;
      tx <= 48'h0;
      pop <= 1'b0;
      ctrl_wr <= 1'b0;
      wr_due <= 1'b0;
      ctrl_val <= 16'h0000;
      write_error_flag <= 1'b0;
      read_error_flag <= 1'b0;
      clock_count_error_flag <= 1'b0;
    end else if (ce) begin
      pop <= 1'b0;
      // 3-wire strobe waits one cycle so ctrl_val already holds the last shifted bit
      ctrl_wr <= wr_due;
      wr_due <= 1'b0;
      ctrl_val <= crc_enable ? rx[23:8] : rx[15:0];
      if (four_wire && (cs_rise || cs_s[1])) begin
        if (cs_rise && state != SCF_CMD) begin
          // flags are only evaluated when CS frames the transfer
          if (error_check_enable) begin
            clock_count_error_flag <= bit_cnt != frame_len;
            write_error_flag <= !cmd[CMD_READ_BIT] && cmd[5:0] != ADDR_CONTROL;
            read_error_flag <= cmd[CMD_READ_BIT] && !known_addr(cmd[5:0]);
          end
          ctrl_wr <= !cmd[CMD_READ_BIT] && cmd[5:0] == ADDR_CONTROL && bit_cnt == frame_len;
        end
        state <= SCF_CMD;
        bit_cnt <= 6'h00;
      end else if (sclk_rise) begin
        bit_cnt <= next_cnt;
        unique case (state)
          SCF_CMD: begin
            cmd_sh <= full_cmd;
            if (next_cnt == CMD_BITS) begin
              cmd <= full_cmd;
              state <= SCF_DATA;
              if (full_cmd[CMD_READ_BIT]) begin
                unique case (full_cmd[5:0])
                  ADDR_DATA: begin
                    if (converter_control[CTRL_STATUS_APPEND]) begin
                      tx <= {buf_data[31:8], buf_data[7:0], 16'h0000};
                    end else begin
                      tx <= {buf_data[31:8], 24'h000000};
                    end
                    pop <= buf_valid;
                  end
                  ADDR_CONTROL: tx <= {converter_control, 32'h0};
                  default: tx <= {conv_status, 40'h0};
                endcase
              end
            end
          end
          SCF_DATA: begin
            rx <= {rx[30:0], din_s[1]};
            if (next_cnt == frame_len) begin
              if (four_wire) begin
                state <= SCF_WAIT;
              end else begin
                state <= SCF_CMD;
                bit_cnt <= 6'h00;
                wr_due <= !cmd[CMD_READ_BIT] && cmd[5:0] == ADDR_CONTROL;
              end
            end
          end
          // extra clocks past the frame are only counted, for the error check and to drop the control write
          SCF_WAIT: rx <= rx;
          default: state <= SCF_CMD;
        endcase
      end else if (sclk_fall && state != SCF_CMD && cmd[CMD_READ_BIT]) begin
        tx <= {tx[46:0], 1'b0};
      end
    end
  end

  // control register; write data lags the capture by one cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      converter_control <= CTRL_RESET;
    end else if (ce && ctrl_wr) begin
      converter_control <= ctrl_val;
    end
  end

  // shared pin: data while a read is in flight, otherwise active-low ready
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drive_data <= 1'b0;
      dly_cnt <= 4'h0;
      data_out_ready_pin <= 1'b1;
      data_out_ready_oe <= 1'b0;
    end else if (ce) begin
      if (state == SCF_CMD && sclk_rise && next_cnt == CMD_BITS && full_cmd[CMD_READ_BIT]) begin
        drive_data <= 1'b1;
      end else if (four_wire && cs_rise) begin
        drive_data <= 1'b0;
      end else if (!four_wire && state == SCF_DATA && sclk_rise && next_cnt == frame_len
                   && drive_data) begin
        dly_cnt <= converter_control[CTRL_OUT_DIS_DELAY] ? DIS_LONG_CYC : DIS_SHORT_CYC;
      end else if (dly_cnt != 4'h0) begin
        dly_cnt <= 4'(dly_cnt - 4'h1);
        if (dly_cnt == 4'h1) begin
          drive_data <= 1'b0;
        end
      end
      if (drive_data && sclk_fall) begin
        data_out_ready_pin <= tx[47];
      end else if (!drive_data) begin
        data_out_ready_pin <= ~buf_valid;
      end
      if (!four_wire && cs_s[1]) begin
        data_out_ready_oe <= 1'b0;
      end else begin
        data_out_ready_oe <= drive_data || ready_on_pin;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reference_output_pin <= 1'b0;
    end else if (ce) begin
      reference_output_pin <= converter_control[CTRL_INT_REF_EN]
                              & converter_control[CTRL_INT_REF_LEVEL];
    end
  end

  // a stalled reader loses no conversion: the converter sees conv_ready drop
  scf_buf2 u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .in_data({conv_data, conv_status}),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(pop)
  );
endmodule
`default_nettype wire

/* tb/scf_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module scf_monitor
  import scf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_out_ready_oe,
  input wire logic conv_valid,
  input wire logic conv_ready,
  input wire logic ready_on_pin,
  input wire logic [15:0] converter_control,
  input wire logic reference_output_pin,
  input wire logic write_error_flag,
  input wire logic read_error_flag,
  input wire logic clock_count_error_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [2:0] flags = {write_error_flag, read_error_flag, clock_count_error_flag};
  wire logic four = converter_control[CTRL_CS_EN];
  rst_vals_a: assert property ($rose(rstn) |-> converter_control == CTRL_RESET && !flags)
    else $error("reset values wrong");
  ref_pin_a: assert property ($stable(converter_control) |-> reference_output_pin ==
    (converter_control[CTRL_INT_REF_EN] & converter_control[CTRL_INT_REF_LEVEL]))
    else $error("reference pin wrong");
  ctrl_update_a: assert property ($changed(converter_control) |-> sclk && $past(sclk, 2))
    else $error("control changed mid frame");
  flags_mode_a: assert property (!four && !$past(four) |-> $stable(flags))
    else $error("error flags moved in 3-wire mode");
  tri_state_a: assert property ((cs_n && !four) [*5] |-> !data_out_ready_oe)
    else $error("pin driven with cs high");
  ready_drive_a: assert property ((cs_n && four && ready_on_pin) [*5] |-> data_out_ready_oe)
    else $error("ready not driven");
  no_route_a: assert property ((cs_n && !ready_on_pin) [*5] |-> !data_out_ready_oe)
    else $error("pin driven without ready route");
  buf_full_a: assert property ($fell(conv_ready) |-> $past(conv_valid))
    else $error("buffer filled without a push");
  cover property ($rose(reference_output_pin));
  cover property ($fell(conv_ready));
  cover property ($rose(write_error_flag));
endmodule
bind scf_top scf_monitor mon (.ref_clk, .rstn, .sclk, .cs_n, .data_out_ready_oe, .conv_valid,
  .conv_ready, .ready_on_pin, .converter_control, .reference_output_pin, .write_error_flag,
  .read_error_flag, .clock_count_error_flag);
`default_nettype wire

/* tb/scf_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scf_host (
  input wire logic ref_clk,
  input wire logic so,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1;
    cs_n = 1;
    din = 1;
  end
  // 4 cycles a half period keeps every edge clear of the 2-stage synchroniser
  task automatic half;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    cs_n = 0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 0;
      din = tx[i];
      half();
      sclk = 1;
      rx[i] = so;
      half();
    end
    cs_n = 1;
    half();
    half();
  endtask
endmodule
`default_nettype wire

/* tb/test_spi_framing_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_spi_framing_control
  import scf_pkg::*;
;
  logic ref_clk = 0, rstn = 0, ce = 1, conv_valid = 0, ready_on_pin = 0;
  logic crc_enable = 0, error_check_enable = 0;
  logic [23:0] conv_data = '0;
  logic [7:0] conv_status = '0;
  logic [47:0] rx;
  wire logic sclk, cs_n, din, pin, oe, conv_ready, ref_pin, wr_err, rd_err, cnt_err;
  wire logic [15:0] ctrl;
  wire logic so = oe ? pin : 1'bz;
  int compares = 0, miscompares = 0;
  scf_top dut (.ref_clk, .rstn, .ce, .sclk, .cs_n, .din, .data_out_ready_pin(pin),
    .data_out_ready_oe(oe), .conv_data, .conv_status, .conv_valid, .conv_ready,
    .ready_on_pin, .crc_enable, .error_check_enable, .converter_control(ctrl),
    .reference_output_pin(ref_pin), .write_error_flag(wr_err), .read_error_flag(rd_err),
    .clock_count_error_flag(cnt_err));
  scf_host host (.ref_clk, .so, .sclk, .cs_n, .din);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic wrap_up;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // command byte leads, data is right aligned behind it
  task automatic xf(input logic [7:0] c, input logic [31:0] d, input int n);
    host.xfer(({40'h0, c} << (n - 8)) | {16'h0, d}, n, rx);
  endtask
  task automatic push(input logic [23:0] d, input logic [7:0] s);
    conv_data = d;
    conv_status = s;
    conv_valid = 1;
    @(negedge ref_clk);
    conv_valid = 0;
  endtask
  initial begin
    #3_000_000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1;
    repeat (3) @(negedge ref_clk);
    xf(8'h41, 0, 24);
    chk(rx[15:0], CTRL_RESET);
    chk({ref_pin, wr_err, rd_err, cnt_err, conv_ready}, 5'h01);
    $display("reset test done");
    xf(8'h01, 32'h6008, 24);
    chk(ref_pin, 1);
    push(24'hA5C3E1, 8'h5A);
    xf(8'h42, 0, 32);
    chk(rx[23:0], 24'hA5C3E1);
    xf(8'h01, 32'h6408, 24);
    push(24'h3C0F96, 8'hC4);
    xf(8'h42, 0, 40);
    chk(rx[31:0], 32'h3C0F96C4);
    $display("3-wire test done");
    conv_valid = 1;
    for (int i = 1; i < 4; i++) begin
      conv_data = {3{8'(i)}};
      conv_status = 8'(i);
      @(negedge ref_clk);
    end
    conv_valid = 0;
    chk(conv_ready, 0);
    crc_enable = 1;
    xf(8'h42, 0, 48);
    chk(rx[39:8], 32'h01010101);
    chk(rx[7:0], 0);
    crc_enable = 0;
    xf(8'h42, 0, 40);
    chk(rx[31:0], 32'h02020202);
    chk(conv_ready, 1);
    $display("buffer test done");
    ready_on_pin = 1;
    error_check_enable = 1;
    xf(8'h01, 32'h6608, 24);
    xf(8'h00, 32'h00, 16);
    chk({wr_err, rd_err, cnt_err}, 3'h4);
    xf(8'h43, 0, 16);
    chk(rd_err, 1);
    // a short write must be dropped and flagged
    xf(8'h01, 32'h008, 20);
    chk(cnt_err, 1);
    xf(8'h41, 0, 24);
    chk(rx[15:0], 16'h6608);
    $display("4-wire test done");
    xf(8'h01, 32'h0000, 24);
    chk({ref_pin, ctrl}, 17'h0);
    $display("reference test done");
    wrap_up();
  end
endmodule
`default_nettype wire
